/* File: plth_pkg.sv */
package plth_pkg;
  // ------------------------------------------------------------
  // Control line codes
  // ------------------------------------------------------------
  localparam logic [1:0] CODE_IDLE = 2'h0; // Idle
  localparam logic [1:0] CODE_HOLD = 2'h1; // Hold
  localparam logic [1:0] CODE_TX = 2'h2; // Transmit
  localparam logic [1:0] CODE_GRANT = 2'h3; // Grant, device only

  // ------------------------------------------------------------
  // Speed codes on the data lines
  // ------------------------------------------------------------
  localparam logic [7:0] SPD_S100 = 8'h00; // Lowest speed
  localparam logic [7:0] SPD_S200 = 8'h40; // Middle speed
  localparam logic [7:0] SPD_S400 = 8'h50; // Top speed
  localparam logic [7:0] DATA_ZERO = 8'h00; // Data lines at rest

  // ------------------------------------------------------------
  // Timing figures, rate in MHz, gap in ns, counts in interface clock cycles
  // ------------------------------------------------------------
  localparam int HOLD_MAX = 47; // Longest allowed hold run
  localparam logic [5:0] HOLD_MAX_W = 6'h2f; // Same figure, counter width
  localparam int CLOCK_MHZ = 50; // Interface clock rate
  localparam int CONCAT_GAP_NS = 160; // Packet separation, plain default
  localparam int CONCAT_GAP_CYC_I = (CONCAT_GAP_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [7:0] CONCAT_GAP_CYC = 8'(CONCAT_GAP_CYC_I); // Cycles of gap

  // ------------------------------------------------------------
  // Handover states, Gray coded in declaration order
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OWN = 3'h0, // Device owns lines, drives idle
    ST_GRANT = 3'h1, // Drive grant
    ST_GIDLE = 3'h3, // Drive idle after grant
    ST_PRE = 3'h2, // Link in optional idle or hold
    ST_TX = 3'h6, // Link transmitting data
    ST_END = 3'h7, // Link in closing idle
    ST_REGAIN = 3'h5, // Device drives first idle again
    ST_GAP = 3'h4 // Packet separation before regrant
  } plth_state_t;
endpackage : plth_pkg

/* File: plth_hold_cnt.sv */
`timescale 1ns/1ps
module plth_hold_cnt (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clear,
  input wire logic count_en,
  output logic over
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0] cnt; // Hold cycles seen, saturating
    logic over; // Limit passed
  } plth_hc_t;

  plth_hc_t q, d;

  // Next state of the hold counter
  always_comb begin
    d = q;
    if (clear) begin
      d.cnt = 6'h00;
      d.over = 1'b0;
    end else if (count_en) begin
      // Past the limit means violation
      if (q.cnt == plth_pkg::HOLD_MAX_W) begin
        d.over = 1'b1; // RQ19
      end else begin
        d.cnt = q.cnt + 6'h01;
      end
    end
  end

  // Register the state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign over = q.over;

  // Forty-eighth hold flags a violation
  chk_hold_limit: assert property (@(posedge clock) disable iff (!nrst) // RQ19
    (!clear && count_en && q.cnt == plth_pkg::HOLD_MAX_W) |=> over)
    else $error("hold limit not flagged");
endmodule : plth_hold_cnt

/* File: plth_transmit.sv */
`timescale 1ns/1ps
// Operation
// RQ1 - Idle, hold, transmit codes from link
// RQ2 - Grant one cycle then one idle
// RQ3 - Release lines after idle following grant
// RQ4 - Link may send one idle first
// RQ5 - Link may hold up to 47 cycles
// RQ6 - Transmit code carries packet data
// RQ7 - Hold ends for concat, idle ends packet
// RQ8 - Link drives one more idle, releases
// RQ9 - Device drives idle after sampling idle
// RQ10 - Extra clock on every direction change
// RQ11 - Concat waits separation, then grants again
// RQ12 - Multispeed concat only when enabled
// RQ13 - Next speed code in ending hold
// RQ14 - Never S100 after a faster packet
// RQ15 - At least one idle before next operation
// RQ16 - Cancel: optional idle, up to 47 holds
// RQ17 - Cancel ends with two idles, release
// RQ18 - Cancel without holds prefers three idles
// RQ19 - Overlong hold is a violation, no data
module plth_transmit (
  input wire logic clock,
  input wire logic nrst,
  input wire logic arb_won,
  input wire logic multispeed_concat_enable,
  input wire logic [1:0] control_lines_in,
  input wire logic [7:0] data_in,
  output logic [1:0] control_lines_out,
  output logic control_lines_oe,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic link_owner,
  output logic phy_ready,
  output logic [7:0] tx_data,
  output logic tx_data_valid,
  output logic tx_packet_end,
  output logic concat_pending,
  output logic [7:0] concat_speed,
  output logic concat_speed_valid,
  output logic speed_error,
  output logic hold_violation
);
  // ------------------------------------------------------------
  // State of the handover
  // ------------------------------------------------------------
  typedef struct packed {
    plth_pkg::plth_state_t st; // Handover state
    logic [1:0] code; // Control lines driven
    logic oe; // Device drives the lines
    logic first; // First link cycle after grant
    logic held; // Link has sent hold
    logic bad; // Hold limit broken this grant
    logic concat; // Concatenation requested
    logic [7:0] cur_speed; // Speed of current packet
    logic [7:0] speed; // Next packet speed
    logic speed_vld; // Next speed captured
    logic speed_err; // Slow after fast
    logic [7:0] txd; // Data forwarded to serial side
    logic txv; // Forwarded data valid
    logic tend; // Packet end pulse
    logic [7:0] gap; // Separation countdown
  } plth_tx_t;

  plth_tx_t q, d;
  logic hold_over; // Hold counter past limit
  logic hc_clear; // Restart hold counter
  logic hc_en; // Count one hold cycle

  // Code shorthands
  function automatic logic is_code(input logic [1:0] v, input logic [1:0] c);
    is_code = (v == c);
  endfunction : is_code

  assign hc_clear = (q.st == plth_pkg::ST_GRANT);
  assign hc_en = (q.st == plth_pkg::ST_PRE) && is_code(control_lines_in, plth_pkg::CODE_HOLD);

  // ------------------------------------------------------------
  // Hold length watch
  // ------------------------------------------------------------
  plth_hold_cnt u_hold (
    .clock(clock),
    .nrst(nrst),
    .clear(hc_clear),
    .count_en(hc_en),
    .over(hold_over)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    d.txv = 1'b0;
    d.tend = 1'b0;
    case (q.st)
      // Device owns lines, idle driven
      plth_pkg::ST_OWN: begin
        if (arb_won) begin
          d.st = plth_pkg::ST_GRANT; // RQ15
        end
      end
      // One grant cycle
      plth_pkg::ST_GRANT: begin
        d.st = plth_pkg::ST_GIDLE; // RQ2
        d.first = 1'b1;
        d.held = 1'b0;
        d.bad = 1'b0;
        d.concat = 1'b0;
      end
      // One idle then release
      plth_pkg::ST_GIDLE: begin
        d.st = plth_pkg::ST_PRE; // RQ3
      end
      // Link idle or hold before data
      plth_pkg::ST_PRE: begin
        d.first = 1'b0;
        if (hold_over) begin
          d.bad = 1'b1; // RQ19
        end
        if (is_code(control_lines_in, plth_pkg::CODE_TX)) begin
          d.st = plth_pkg::ST_TX; // RQ1
          d.txd = data_in; // RQ6
          d.txv = !(q.bad || hold_over); // RQ19
        end else if (is_code(control_lines_in, plth_pkg::CODE_HOLD)) begin
          d.held = 1'b1; // RQ5
        end else if (!q.first || q.held) begin
          // Idle after the optional one: cancel
          d.st = plth_pkg::ST_END; // RQ17
        end
      end
      // Link sends packet data
      plth_pkg::ST_TX: begin
        if (is_code(control_lines_in, plth_pkg::CODE_TX)) begin
          d.txd = data_in; // RQ6
          d.txv = !q.bad;
        end else begin
          d.st = plth_pkg::ST_END; // RQ7
          d.tend = 1'b1;
          if (is_code(control_lines_in, plth_pkg::CODE_HOLD)) begin
            d.concat = 1'b1; // RQ7
            if (multispeed_concat_enable) begin
              d.speed = data_in; // RQ13
              d.speed_vld = 1'b1; // RQ12
              d.speed_err = (data_in == plth_pkg::SPD_S100) &&
                            (q.cur_speed != plth_pkg::SPD_S100); // RQ14
            end
          end
        end
      end
      // Link closing idle, then device takes back
      plth_pkg::ST_END: begin
        if (is_code(control_lines_in, plth_pkg::CODE_IDLE)) begin
          d.st = plth_pkg::ST_REGAIN; // RQ9
        end
      end
      // First idle after regaining lines
      plth_pkg::ST_REGAIN: begin
        if (q.concat) begin
          d.st = plth_pkg::ST_GAP; // RQ11
          d.gap = plth_pkg::CONCAT_GAP_CYC - 8'h01;
          if (q.speed_vld) begin
            d.cur_speed = q.speed;
          end
        end else begin
          d.st = plth_pkg::ST_OWN; // RQ15
        end
      end
      // Packet separation, serial bus kept
      plth_pkg::ST_GAP: begin
        if (q.gap == 8'h00) begin
          d.st = plth_pkg::ST_GRANT; // RQ11
          d.speed_vld = 1'b0;
        end else begin
          d.gap = q.gap - 8'h01;
        end
      end
      default: begin
        d.st = plth_pkg::ST_OWN;
      end
    endcase
    // Line drive follows the next state
    case (d.st)
      plth_pkg::ST_GRANT: begin
        d.code = plth_pkg::CODE_GRANT; // RQ2
        d.oe = 1'b1;
      end
      plth_pkg::ST_PRE, plth_pkg::ST_TX, plth_pkg::ST_END: begin
        d.code = plth_pkg::CODE_IDLE; // RQ10
        d.oe = 1'b0;
      end
      default: begin
        d.code = plth_pkg::CODE_IDLE; // RQ15
        d.oe = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Register the state
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= '{st: plth_pkg::ST_OWN, code: plth_pkg::CODE_IDLE, oe: 1'b1,
             cur_speed: plth_pkg::SPD_S100, speed: plth_pkg::SPD_S100, default: '0};
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign control_lines_out = q.code;
  assign control_lines_oe = q.oe;
  assign data_out = plth_pkg::DATA_ZERO;
  assign data_oe = q.oe;
  assign link_owner = !q.oe;
  assign phy_ready = (q.st == plth_pkg::ST_OWN);
  assign tx_data = q.txd;
  assign tx_data_valid = q.txv;
  assign tx_packet_end = q.tend;
  assign concat_pending = q.concat;
  assign concat_speed = q.speed;
  assign concat_speed_valid = q.speed_vld;
  assign speed_error = q.speed_err;
  assign hold_violation = q.bad;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_grant_then_idle: assert property (@(posedge clock) disable iff (!nrst) // RQ2
    (control_lines_oe && control_lines_out == plth_pkg::CODE_GRANT) |=>
    (control_lines_oe && control_lines_out == plth_pkg::CODE_IDLE))
    else $error("grant not followed by idle");

  chk_grant_release: assert property (@(posedge clock) disable iff (!nrst) // RQ3
    (control_lines_oe && control_lines_out == plth_pkg::CODE_GRANT) |=>
    ##1 (!control_lines_oe && !data_oe))
    else $error("lines not released after grant idle");

  chk_regain_idle: assert property (@(posedge clock) disable iff (!nrst) // RQ9
    (q.st == plth_pkg::ST_END && control_lines_in == plth_pkg::CODE_IDLE) |=>
    (control_lines_oe && control_lines_out == plth_pkg::CODE_IDLE))
    else $error("idle not driven after link idle");

  chk_idle_first: assert property (@(posedge clock) disable iff (!nrst) // RQ15
    $rose(control_lines_oe) |-> (control_lines_out == plth_pkg::CODE_IDLE) ##1
    (control_lines_out == plth_pkg::CODE_IDLE))
    else $error("no idle after regaining lines");

  chk_concat_gap: assert property (@(posedge clock) disable iff (!nrst) // RQ11
    (q.st == plth_pkg::ST_REGAIN && q.concat) |=>
    (control_lines_out == plth_pkg::CODE_IDLE)[*8] ##1 (control_lines_out == plth_pkg::CODE_GRANT))
    else $error("concatenation regrant timing wrong");

  chk_tx_forward: assert property (@(posedge clock) disable iff (!nrst) // RQ6
    (q.st == plth_pkg::ST_TX && control_lines_in == plth_pkg::CODE_TX && !q.bad) |=>
    (tx_data_valid && tx_data == $past(data_in)))
    else $error("packet data not forwarded");

  chk_speed_capture: assert property (@(posedge clock) disable iff (!nrst) // RQ13
    (q.st == plth_pkg::ST_TX && control_lines_in == plth_pkg::CODE_HOLD && multispeed_concat_enable) |=>
    (concat_speed_valid && concat_speed == $past(data_in) && concat_pending))
    else $error("concatenation speed not captured");

  chk_speed_off: assert property (@(posedge clock) disable iff (!nrst) // RQ12
    (q.st == plth_pkg::ST_GRANT) |=> !concat_speed_valid ##1
    (!concat_speed_valid throughout (q.st == plth_pkg::ST_PRE)))
    else $error("stale speed code kept");

  chk_bad_no_data: assert property (@(posedge clock) disable iff (!nrst) // RQ19
    (hold_violation && q.st == plth_pkg::ST_TX) |=> !tx_data_valid)
    else $error("data forwarded after hold violation");
endmodule : plth_transmit

/* File: plth_link_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Link-side partner on the control and data lines
// ------------------------------------------------------------
module plth_link_model (
  input wire logic clock,
  input wire logic [1:0] code_wire,
  output logic link_oe,
  output logic [1:0] link_code,
  output logic [7:0] link_d
);
  // Released at time zero
  initial begin
    link_oe = 1'b0;
    link_code = 2'h0;
    link_d = 8'h00;
  end

  // One cycle of code and data, changed at the falling edge
  task automatic put(input logic [1:0] c, input logic [7:0] d);
    link_code = c;
    link_d = d;
    @(negedge clock);
  endtask : put

  // One ownership: optional idle, holds, bytes, closing codes
  task automatic run(input bit pre, input int holds, input int bytes, input bit endh, input logic [7:0] spd);
    int i;
    do @(negedge clock); while (code_wire !== plth_pkg::CODE_GRANT);
    // Skip the rest of the grant cycle and the grant idle; drive from the first released cycle
    repeat (2) @(negedge clock);
    link_oe = 1'b1;
    if (pre) put(plth_pkg::CODE_IDLE, 8'h00);
    for (i = 0; i < holds; i++) put(plth_pkg::CODE_HOLD, 8'(i));
    for (i = 0; i < bytes; i++) put(plth_pkg::CODE_TX, 8'h30 + 8'(i));
    if (bytes > 0) put(endh ? plth_pkg::CODE_HOLD : plth_pkg::CODE_IDLE, endh ? spd : 8'h00);
    else if (!pre && holds == 0) put(plth_pkg::CODE_IDLE, 8'h00);
    if (bytes == 0) put(plth_pkg::CODE_IDLE, 8'h00);
    put(plth_pkg::CODE_IDLE, 8'h00);
    // Release; data no longer shows the last value
    link_oe = 1'b0;
    link_d = ~link_d;
  endtask : run
endmodule : plth_link_model

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic arb_won = 1'b0;
  logic mse = 1'b0; // Multispeed concat enable pin
  logic [1:0] code_out;
  logic code_oe;
  logic [7:0] data_out;
  logic data_oe;
  logic link_owner;
  logic phy_ready;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_end;
  logic cpend;
  logic [7:0] cspd;
  logic cspd_valid;
  logic speed_error;
  logic hold_violation;
  logic link_oe;
  logic [1:0] link_code;
  logic [7:0] link_d;
  logic oe_q = 1'b1; // Previous device enable
  int err_count = 0;
  int compares = 0;
  int cyc = 0; // Cycle count
  int grants = 0; // Grant cycles seen
  int regain_cyc = 0; // Cycle the device took lines back
  int end_cyc = 0; // Cycle of packet end pulse
  int gap_cyc = 0; // Regain to grant distance
  logic [7:0] got[$]; // Forwarded bytes
  // Bus holder keeps released control lines at idle
  wire [1:0] code_w = code_oe ? code_out : (link_oe ? link_code : 2'h0);
  wire [7:0] data_w = data_oe ? data_out : link_d;

  always #10 clock = ~clock;

  // ------------------------------------------------------------
  // Device and link partner
  // ------------------------------------------------------------
  plth_transmit i_dut (.clock(clock), .nrst(nrst), .arb_won(arb_won), .multispeed_concat_enable(mse),
    .control_lines_in(code_w), .data_in(data_w), .control_lines_out(code_out), .control_lines_oe(code_oe),
    .data_out(data_out), .data_oe(data_oe), .link_owner(link_owner), .phy_ready(phy_ready),
    .tx_data(tx_data), .tx_data_valid(tx_valid), .tx_packet_end(tx_end), .concat_pending(cpend),
    .concat_speed(cspd), .concat_speed_valid(cspd_valid), .speed_error(speed_error),
    .hold_violation(hold_violation));
  plth_link_model i_link (.clock(clock), .code_wire(code_w), .link_oe(link_oe), .link_code(link_code),
    .link_d(link_d));

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Collects bytes, grants and regain moments
  always @(posedge clock) begin
    cyc <= cyc + 1;
    oe_q <= code_oe;
    if (tx_valid === 1'b1) got.push_back(tx_data);
    if (tx_end === 1'b1) end_cyc <= cyc;
    if (code_oe === 1'b1 && oe_q === 1'b0) begin
      regain_cyc <= cyc;
      chk(code_out, plth_pkg::CODE_IDLE);
    end
    if (code_out === plth_pkg::CODE_GRANT && code_oe === 1'b1) begin
      grants <= grants + 1;
      gap_cyc <= cyc - regain_cyc;
    end
  end

  // One grant and ownership, checking the handover
  task automatic xfer(input bit arb, input bit pre, input int h, input int b, input bit eh, input logic [7:0] s);
    got.delete();
    arb_won = arb;
    fork
      i_link.run(pre, h, b, eh, s);
      begin
        @(negedge clock);
        arb_won = 1'b0;
        while (!(code_out === plth_pkg::CODE_GRANT && code_oe === 1'b1)) @(negedge clock);
        @(negedge clock);
        chk({code_oe, code_out, data_oe, data_out}, {1'b1, plth_pkg::CODE_IDLE, 1'b1, 8'h00});
        @(negedge clock);
        chk({code_oe, data_oe, link_owner}, 3'b001);
      end
    join
    repeat (3) @(negedge clock);
  endtask : xfer

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    chk({code_oe, code_out, phy_ready}, 4'b1001);
    chk({hold_violation, cpend, cspd_valid, speed_error}, 4'h0);
  endtask : t_reset

  task automatic t_normal();
    xfer(1, 1, 2, 3, 0, 8'h00);
    chk(got.size(), 3);
    foreach (got[i]) chk(got[i], 8'h30 + 8'(i));
    chk(regain_cyc - end_cyc, 1);
    chk({cpend, phy_ready}, 2'b01);
  endtask : t_normal

  task automatic t_busy_arb();
    int g0;
    g0 = grants;
    fork
      xfer(1, 0, 0, 2, 0, 8'h00);
      begin
        repeat (6) @(negedge clock);
        arb_won = 1'b1;
        @(negedge clock);
        arb_won = 1'b0;
      end
    join
    repeat (12) @(negedge clock);
    chk(grants - g0, 1);
  endtask : t_busy_arb

  task automatic t_concat();
    mse = 1'b1;
    xfer(1, 0, 1, 2, 1, plth_pkg::SPD_S400);
    chk({cpend, cspd_valid, cspd}, {2'b11, plth_pkg::SPD_S400});
    xfer(0, 0, 0, 2, 1, plth_pkg::SPD_S100);
    chk(gap_cyc, 32'(plth_pkg::CONCAT_GAP_CYC) + 1);
    chk(speed_error, 1);
    xfer(0, 0, 0, 1, 0, 8'h00);
    chk({cpend, phy_ready}, 2'b01);
    mse = 1'b0;
    xfer(1, 0, 0, 1, 1, plth_pkg::SPD_S200);
    chk({cpend, cspd_valid}, 2'b10);
    xfer(0, 0, 0, 1, 0, 8'h00);
  endtask : t_concat

  task automatic t_cancel();
    xfer(1, 1, 0, 0, 0, 8'h00);
    chk({got.size() == 0, phy_ready}, 2'b11);
    xfer(1, 0, 0, 0, 0, 8'h00);
    chk({got.size() == 0, phy_ready}, 2'b11);
    xfer(1, 1, 5, 0, 0, 8'h00);
    chk({got.size() == 0, phy_ready}, 2'b11);
  endtask : t_cancel

  task automatic t_hold();
    xfer(1, 0, 48, 2, 0, 8'h00);
    chk({hold_violation, got.size() == 0}, 2'b11);
    xfer(1, 1, 47, 2, 0, 8'h00);
    chk({hold_violation, got.size() == 2}, 2'b01);
  endtask : t_hold

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    t_reset();
    t_normal();
    t_busy_arb();
    t_concat();
    t_cancel();
    t_hold();
    report_and_stop();
  end

  // Cuts a hang well past the expected run length
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
endmodule : testbench
